// >>> period_timer_pkg.sv
// Package for the period timer: register map, field layout, reset values, state types.
// Assumes one clock domain and a simple strobe register port with read data one cycle late.
`default_nettype none

package period_timer_pkg;

  // Register offsets on the byte-wide register port.
  localparam logic [7:0] flags_addr = 8'h0c;
  localparam logic [7:0] count_addr = 8'h11;
  localparam logic [7:0] control_addr = 8'h12;
  localparam logic [7:0] enables_addr = 8'h8c;
  localparam logic [7:0] period_addr = 8'h92;

  // Field positions.
  localparam int flag_bit = 1;
  localparam int enable_bit = 1;
  localparam int run_bit = 2;
  localparam int post_lsb = 3;
  localparam int post_msb = 6;
  localparam int pre_lsb = 0;
  localparam int pre_msb = 1;

  // Reset values.
  localparam logic [7:0] count_reset = 8'h00;
  localparam logic [6:0] control_reset = 7'h00;
  localparam logic [7:0] period_reset = 8'hff;
  localparam logic [7:0] read_idle = 8'h00;

  // Prescaler terminal counts: divide by 1, 4 and 16.
  localparam logic [3:0] pre_last_div1 = 4'h0;
  localparam logic [3:0] pre_last_div4 = 4'h3;
  localparam logic [3:0] pre_last_div16 = 4'hf;
  localparam logic [1:0] pre_sel_div1 = 2'h0;
  localparam logic [1:0] pre_sel_div4 = 2'h1;

  // Register port request from software.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  // Time base handed to the serial port and the PWM units.
  typedef struct packed {
    logic [7:0] count;
    logic match;
  } time_base_type;

  // State of a scaler counter.
  typedef struct packed {
    logic [3:0] cnt;
  } scaler_state_type;

  // State of the timer proper.
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period;
    logic [6:0] control;
    logic flag;
    logic irq_en;
    logic irq;
    logic match;
    logic [7:0] rdata;
  } timer_state_type;

endpackage

`default_nettype wire

// >>> period_timer_scalers.sv
// Prescale divider and postscale counter used by the period timer.
// Assumes the clear input is a synchronous one-cycle request from the register logic.
`default_nettype none

module prescale_divider (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Control.
  input wire logic clear,
  input wire logic enable,
  input wire logic [3:0] last,
  // Result.
  output logic tick,
  output logic [3:0] cnt
);

  period_timer_pkg::scaler_state_type st_q;
  period_timer_pkg::scaler_state_type st_d;

  // A clear also suppresses the tick so a write never counts as an increment.
  always_comb
  begin
    st_d = st_q;
    tick = 1'b0;
    if (clear)
    begin
      st_d.cnt = 4'h0;
    end
    else if (enable)
    begin
      if (st_q.cnt >= last)
      begin
        st_d.cnt = 4'h0;
        tick = 1'b1;
      end
      else
      begin
        st_d.cnt = st_q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign cnt = st_q.cnt;

endmodule

module postscale_counter (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Control.
  input wire logic clear,
  input wire logic match,
  input wire logic [3:0] ratio,
  // Result.
  output logic done,
  output logic [3:0] cnt
);

  period_timer_pkg::scaler_state_type st_q;
  period_timer_pkg::scaler_state_type st_d;

  always_comb
  begin
    st_d = st_q;
    done = 1'b0;
    if (clear)
    begin
      st_d.cnt = 4'h0;
    end
    else if (match)
    begin
      if (st_q.cnt >= ratio)
      begin
        st_d.cnt = 4'h0;
        done = 1'b1;
      end
      else
      begin
        st_d.cnt = st_q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign cnt = st_q.cnt;

endmodule

`default_nettype wire

// >>> period_timer.sv
// Eight-bit period timer with prescaler, period limit and postscaled flag.
// Assumes sys_clk is the instruction clock and software uses the strobe register port.
//
// How it works
// [RL1] Count register is read/write and clears to zero on reset.
// [RL2] Prescale field selects divide by 1, 4 or 16 of the clock.
// [RL3] Count rises from zero; at period limit it wraps to zero with match.
// [RL4] Period limit register is read/write and resets to all ones.
// [RL5] Matches pass a 4-bit postscaler; flag sets every N matches, N 1..16.
// [RL6] Control bits 6..3 value k gives postscale ratio k+1.
// [RL7] Timer counts only while control bit 2 is one.
// [RL8] Count or control writes, and reset, clear both scaler counters.
// [RL9] A control write leaves the count value unchanged.
// [RL10] Unscaled match pulse goes out to the sync serial port.
// [RL11] Control bit 7 reads zero; implemented control bits reset to zero.
// [RL12] Count and match are offered to the PWM units as time base.
// [RL13] Flag holds until software writes zero; request gated by enable bit.
`default_nettype none

module period_timer (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port.
  input wire period_timer_pkg::bus_req_type bus_req,
  output logic [7:0] rdata_q,
  // Interrupt request.
  output logic irq_q,
  // Time base for the sync serial port and PWM units.
  output period_timer_pkg::time_base_type time_base_q
);

  period_timer_pkg::timer_state_type st_q;
  period_timer_pkg::timer_state_type st_d;

  logic wr_count;
  logic wr_control;
  logic wr_period;
  logic wr_flags;
  logic wr_enables;
  logic scaler_clear;
  logic run;
  logic pre_tick;
  logic [3:0] pre_cnt;
  logic [3:0] pre_last;
  logic [1:0] pre_sel;
  logic [3:0] post_ratio;
  logic at_limit;
  logic match_now;
  logic post_done;
  logic [3:0] post_cnt;

  // Address decode.
  assign wr_count = bus_req.wr && (bus_req.addr == period_timer_pkg::count_addr);
  assign wr_control = bus_req.wr && (bus_req.addr == period_timer_pkg::control_addr);
  assign wr_period = bus_req.wr && (bus_req.addr == period_timer_pkg::period_addr);
  assign wr_flags = bus_req.wr && (bus_req.addr == period_timer_pkg::flags_addr);
  assign wr_enables = bus_req.wr && (bus_req.addr == period_timer_pkg::enables_addr);

  // [RL8] Scaler clear on writes.
  assign scaler_clear = wr_count || wr_control;

  // [RL7] Run bit gate.
  assign run = st_q.control[period_timer_pkg::run_bit];

  // [RL2] Prescale selection.
  assign pre_sel = st_q.control[period_timer_pkg::pre_msb:period_timer_pkg::pre_lsb];
  always_comb
  begin
    case (pre_sel)
      period_timer_pkg::pre_sel_div1: pre_last = period_timer_pkg::pre_last_div1;
      period_timer_pkg::pre_sel_div4: pre_last = period_timer_pkg::pre_last_div4;
      default: pre_last = period_timer_pkg::pre_last_div16;
    endcase
  end

  prescale_divider u_prescale (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clear(scaler_clear),
    .enable(run),
    .last(pre_last),
    .tick(pre_tick),
    .cnt(pre_cnt)
  );

  // [RL3] Match when the count sits at the limit on an increment.
  assign at_limit = (st_q.count == st_q.period);
  assign match_now = pre_tick && at_limit && !wr_count;

  // [RL6] Postscale ratio field.
  assign post_ratio = st_q.control[period_timer_pkg::post_msb:period_timer_pkg::post_lsb];

  // [RL5] Postscaler on matches.
  postscale_counter u_postscale (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clear(scaler_clear),
    .match(match_now),
    .ratio(post_ratio),
    .done(post_done),
    .cnt(post_cnt)
  );

  always_comb
  begin
    st_d = st_q;
    // [RL1] Count register write.
    if (wr_count)
    begin
      st_d.count = bus_req.wdata;
    end
    else if (pre_tick)
    begin
      // [RL3] Wrap at period limit.
      if (at_limit)
      begin
        st_d.count = 8'h00;
      end
      else
      begin
        st_d.count = st_q.count + 8'h01;
      end
    end
    // [RL9] Control write keeps count.
    if (wr_control)
    begin
      st_d.control = bus_req.wdata[6:0];
    end
    // [RL4] Period limit write.
    if (wr_period)
    begin
      st_d.period = bus_req.wdata;
    end
    if (wr_enables)
    begin
      st_d.irq_en = bus_req.wdata[period_timer_pkg::enable_bit];
    end
    // [RL13] Sticky flag; a postscaler event beats a clearing write.
    if (wr_flags)
    begin
      st_d.flag = bus_req.wdata[period_timer_pkg::flag_bit];
    end
    if (post_done)
    begin
      st_d.flag = 1'b1;
    end
    st_d.irq = st_d.flag && st_d.irq_en;
    // [RL10] Match pulse for the serial port and PWM.
    st_d.match = match_now;
    // [RL11] Read mux; bit 7 of control and unused bits read zero.
    st_d.rdata = period_timer_pkg::read_idle;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        period_timer_pkg::count_addr: st_d.rdata = st_q.count;
        period_timer_pkg::control_addr: st_d.rdata = {1'b0, st_q.control};
        period_timer_pkg::period_addr: st_d.rdata = st_q.period;
        period_timer_pkg::flags_addr:
          st_d.rdata = {6'h00, st_q.flag, 1'b0};
        period_timer_pkg::enables_addr:
          st_d.rdata = {6'h00, st_q.irq_en, 1'b0};
        default: st_d.rdata = period_timer_pkg::read_idle;
      endcase
    end
  end

  // [RL1] Reset values of all state.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q.count <= period_timer_pkg::count_reset;
      st_q.period <= period_timer_pkg::period_reset;
      st_q.control <= period_timer_pkg::control_reset;
      st_q.flag <= 1'b0;
      st_q.irq_en <= 1'b0;
      st_q.irq <= 1'b0;
      st_q.match <= 1'b0;
      st_q.rdata <= period_timer_pkg::read_idle;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // [RL12] Time base out, straight from flip-flops.
  assign time_base_q = {st_q.count, st_q.match};
  assign rdata_q = st_q.rdata;
  assign irq_q = st_q.irq;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  chk_count_write: assert property ( // [RL1]
    wr_count |=> st_q.count == $past(bus_req.wdata))
    else $error("count write not taken");

  chk_count_wrap: assert property ( // [RL3]
    (pre_tick && at_limit && !wr_count) |=> (st_q.count == 8'h00) && time_base_q.match)
    else $error("count did not wrap with a match");

  chk_period_write: assert property ( // [RL4]
    wr_period |=> st_q.period == $past(bus_req.wdata))
    else $error("period write not taken");

  chk_run_stop: assert property ( // [RL7]
    (!run && !wr_count) |=> $stable(st_q.count) && !time_base_q.match)
    else $error("count moved while stopped");

  chk_scaler_clear: assert property ( // [RL8]
    scaler_clear |=> (pre_cnt == 4'h0) && (post_cnt == 4'h0))
    else $error("scalers not cleared by write");

  chk_control_keeps: assert property ( // [RL9]
    (wr_control && !wr_count) |=> st_q.count == $past(st_q.count))
    else $error("control write changed count");

  chk_bit7_zero: assert property ( // [RL11]
    (bus_req.rd && bus_req.addr == period_timer_pkg::control_addr) |=> rdata_q[7] == 1'b0)
    else $error("control bit 7 read as one");

  chk_flag_source: assert property ( // [RL5]
    ($rose(st_q.flag) && !$past(wr_flags)) |-> time_base_q.match)
    else $error("flag rose without a match");

  chk_flag_sticky: assert property ( // [RL13]
    (st_q.flag && !wr_flags) |=> st_q.flag)
    else $error("flag dropped without a write");

  chk_irq_gate: assert property ( // [RL13]
    (wr_enables && bus_req.wdata[period_timer_pkg::enable_bit] && st_q.flag) |=> irq_q)
    else $error("request missing with flag and enable");

  chk_div16_gap: assert property ( // [RL2]
    (pre_tick && pre_sel[1]) |=> !(pre_tick && pre_sel[1]) [*8])
    else $error("divide by 16 ticked too soon");

  chk_count_read: assert property ( // [RL1]
    (bus_req.rd && bus_req.addr == period_timer_pkg::count_addr)
      |=> rdata_q == $past(st_q.count))
    else $error("count read returned a wrong value");

  chk_period_read: assert property ( // [RL4]
    (bus_req.rd && bus_req.addr == period_timer_pkg::period_addr)
      |=> rdata_q == $past(st_q.period))
    else $error("period read returned a wrong value");

  chk_period_keeps: assert property ( // [RL4]
    !wr_period |=> $stable(st_q.period))
    else $error("period limit changed without a write");

  chk_count_step: assert property ( // [RL3]
    (pre_tick && !at_limit && !wr_count) |=> st_q.count == $past(st_q.count) + 8'h01)
    else $error("count did not step by one");

  chk_wrap_only: assert property ( // [RL3]
    (!wr_count && !at_limit && st_q.count != 8'h00 && st_q.count != 8'hff)
      |=> st_q.count != 8'h00)
    else $error("count returned to zero away from the limit");

  chk_write_no_match: assert property ( // [RL3]
    wr_count |=> !time_base_q.match)
    else $error("count write produced a match");

  chk_div1_tick: assert property ( // [RL2]
    (run && pre_sel == period_timer_pkg::pre_sel_div1 && !scaler_clear) |-> pre_tick)
    else $error("divide by 1 missed a tick");

  chk_div4_gap: assert property ( // [RL2]
    (pre_tick && pre_sel == period_timer_pkg::pre_sel_div4)
      |=> !(pre_tick && pre_sel == period_timer_pkg::pre_sel_div4) [*3])
    else $error("divide by 4 ticked too soon");

  chk_stop_holds: assert property ( // [RL7]
    (!run && !scaler_clear) |=> $stable(pre_cnt) && $stable(post_cnt))
    else $error("scalers moved while stopped");

  chk_pre_clear: assert property ( // [RL8]
    scaler_clear |-> !pre_tick)
    else $error("tick in a clearing cycle");

  chk_post_count: assert property ( // [RL5]
    (match_now && post_cnt < post_ratio)
      |=> post_cnt == $past(post_cnt) + 4'h1)
    else $error("postscaler did not count a match");

  chk_post_hold: assert property ( // [RL5]
    (!match_now && !scaler_clear) |=> $stable(post_cnt))
    else $error("postscaler moved without a match");

  chk_control_takes: assert property ( // [RL6]
    wr_control |=> st_q.control == $past(bus_req.wdata[6:0]))
    else $error("control write not taken");

  chk_match_needs: assert property ( // [RL10]
    !(pre_tick && at_limit) |=> !time_base_q.match)
    else $error("match without a limit increment");

  chk_match_pulse: assert property ( // [RL10]
    time_base_q.match |-> time_base_q.count == 8'h00)
    else $error("match shown with a nonzero count");

  chk_control_read: assert property ( // [RL11]
    (bus_req.rd && bus_req.addr == period_timer_pkg::control_addr)
      |=> rdata_q == {1'b0, $past(st_q.control)})
    else $error("control read returned a wrong value");

  chk_flags_read: assert property ( // [RL13]
    (bus_req.rd && bus_req.addr == period_timer_pkg::flags_addr)
      |=> rdata_q == {6'h00, $past(st_q.flag), 1'b0})
    else $error("flag read returned a wrong value");

  chk_enables_read: assert property ( // [RL13]
    (bus_req.rd && bus_req.addr == period_timer_pkg::enables_addr)
      |=> rdata_q == {6'h00, $past(st_q.irq_en), 1'b0})
    else $error("enable read returned a wrong value");

  chk_enable_write: assert property ( // [RL13]
    wr_enables
      |=> st_q.irq_en == $past(bus_req.wdata[period_timer_pkg::enable_bit]))
    else $error("enable write not taken");

  chk_flag_clear: assert property ( // [RL13]
    (wr_flags && !bus_req.wdata[period_timer_pkg::flag_bit] && !post_done)
      |=> !st_q.flag)
    else $error("flag not cleared by a write");

  chk_set_wins: assert property ( // [RL13]
    post_done |=> st_q.flag)
    else $error("postscaler event did not set the flag");

  chk_irq_masked: assert property ( // [RL13]
    (wr_enables && !bus_req.wdata[period_timer_pkg::enable_bit]) |=> !irq_q)
    else $error("request while the enable is off");

  cov_match: cover property (time_base_q.match);
  cov_flag: cover property ($rose(st_q.flag));
  cov_irq: cover property (irq_q);
  cov_set_beats_clear: cover property (post_done && wr_flags);
  cov_post16: cover property (post_done && post_ratio == 4'hf);

endmodule

`default_nettype wire

// >>> period_timer_bench.sv
// Self-checking bench for the period timer: register port, scalers, flag and time base.
// Assumes one 25 MHz clock and the strobe register port with read data one cycle late.
`default_nettype none

module period_timer_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk;
  logic rst_b;
  period_timer_pkg::bus_req_type bus_req;
  logic [7:0] rdata_q;
  logic irq_q;
  period_timer_pkg::time_base_type time_base_q;
  int n_errors;
  int samples_checked;

  period_timer uut (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .bus_req(bus_req),
    .rdata_q(rdata_q),
    .irq_q(irq_q),
    .time_base_q(time_base_q)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask

  task automatic chk_n(input string name, input int exp, input int got);
    samples_checked++;
    if (got != exp)
    begin
      $display("ERROR %s expected %0d seen %0d", name, exp, got);
      n_errors++;
    end
  endtask

  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    bus_req.addr <= addr;
    bus_req.wdata <= data;
    bus_req.wr <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask

  // Read data is sampled just after the edge that follows the strobe cycle.
  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [7:0] exp);
    @(posedge sys_clk);
    bus_req.addr <= addr;
    bus_req.rd <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    chk8(name, exp, rdata_q);
  endtask

  // Counts edges from the last write until the unscaled match pulse shows.
  task automatic measure(output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (time_base_q.match !== 1'b1 && n < 2000);
  endtask

  task automatic t_reset();
    rd_chk("flags", period_timer_pkg::flags_addr, 8'h00);
    rd_chk("count", period_timer_pkg::count_addr, 8'h00);
    rd_chk("control", period_timer_pkg::control_addr, 8'h00);
    rd_chk("enables", period_timer_pkg::enables_addr, 8'h00);
    rd_chk("period", period_timer_pkg::period_addr, 8'hff);
    rd_chk("unmapped", 8'h20, 8'h00);
    chk8("irq", 8'h00, {7'h00, irq_q});
  endtask

  task automatic t_regs();
    wr_reg(period_timer_pkg::period_addr, 8'h5a);
    rd_chk("period", period_timer_pkg::period_addr, 8'h5a);
    wr_reg(period_timer_pkg::control_addr, 8'hfb);
    rd_chk("control", period_timer_pkg::control_addr, 8'h7b);
    wr_reg(period_timer_pkg::control_addr, 8'h00);
    wr_reg(period_timer_pkg::count_addr, 8'h40);
    repeat (20) @(posedge sys_clk);
    rd_chk("stopped count", period_timer_pkg::count_addr, 8'h40);
    wr_reg(period_timer_pkg::control_addr, 8'h78);
    rd_chk("count kept", period_timer_pkg::count_addr, 8'h40);
    chk8("time base count", 8'h40, time_base_q.count);
  endtask

  // Select value 3 must behave as divide by 16, like value 2.
  task automatic t_prescale();
    int n;
    int div;
    for (int sel = 0; sel < 4; sel++)
    begin
      div = (sel == 0) ? 1 : ((sel == 1) ? 4 : 16);
      wr_reg(period_timer_pkg::control_addr, 8'h00);
      wr_reg(period_timer_pkg::period_addr, 8'h03);
      wr_reg(period_timer_pkg::count_addr, 8'h00);
      wr_reg(period_timer_pkg::control_addr, 8'h04 | 8'(sel));
      measure(n);
      chk_n("edges to match", 4 * div, n);
    end
  endtask

  // A count write in mid-prescale must restart the prescaler from zero.
  task automatic t_clear();
    int n;
    wr_reg(period_timer_pkg::period_addr, 8'h02);
    wr_reg(period_timer_pkg::control_addr, 8'h06);
    repeat (5) @(posedge sys_clk);
    wr_reg(period_timer_pkg::count_addr, 8'h00);
    measure(n);
    chk_n("edges after count write", 48, n);
  endtask

  task automatic t_postscale();
    int n;
    int i;
    int ks[3] = '{0, 1, 15};
    wr_reg(period_timer_pkg::enables_addr, 8'h02);
    foreach (ks[j])
    begin
      wr_reg(period_timer_pkg::control_addr, 8'h00);
      wr_reg(period_timer_pkg::flags_addr, 8'h00);
      wr_reg(period_timer_pkg::period_addr, 8'h01);
      wr_reg(period_timer_pkg::count_addr, 8'h00);
      wr_reg(period_timer_pkg::control_addr, 8'h04 | 8'(ks[j] << 3));
      n = 0;
      i = 0;
      while (irq_q !== 1'b1 && i < 200)
      begin
        @(posedge sys_clk);
        #1;
        if (time_base_q.match === 1'b1)
          n++;
        i++;
      end
      chk_n("matches per flag", ks[j] + 1, n);
      rd_chk("flag set", period_timer_pkg::flags_addr, 8'h02);
    end
  endtask

  task automatic t_irq_mask();
    wr_reg(period_timer_pkg::control_addr, 8'h00);
    wr_reg(period_timer_pkg::enables_addr, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk8("masked irq", 8'h00, {7'h00, irq_q});
    rd_chk("flag held", period_timer_pkg::flags_addr, 8'h02);
    wr_reg(period_timer_pkg::enables_addr, 8'h02);
    repeat (2) @(posedge sys_clk);
    chk8("unmasked irq", 8'h01, {7'h00, irq_q});
    wr_reg(period_timer_pkg::flags_addr, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk8("cleared irq", 8'h00, {7'h00, irq_q});
    rd_chk("flag cleared", period_timer_pkg::flags_addr, 8'h00);
  endtask

  // Period zero at 1:1 matches every cycle, so the clearing write meets a set.
  task automatic t_set_wins();
    wr_reg(period_timer_pkg::control_addr, 8'h00);
    wr_reg(period_timer_pkg::period_addr, 8'h00);
    wr_reg(period_timer_pkg::count_addr, 8'h00);
    wr_reg(period_timer_pkg::control_addr, 8'h04);
    wr_reg(period_timer_pkg::flags_addr, 8'h00);
    rd_chk("flag set wins", period_timer_pkg::flags_addr, 8'h02);
    chk8("match held", 8'h01, {7'h00, time_base_q.match});
    wr_reg(period_timer_pkg::control_addr, 8'h00);
    wr_reg(period_timer_pkg::flags_addr, 8'h00);
    rd_chk("flag after stop", period_timer_pkg::flags_addr, 8'h00);
    rd_chk("count at limit", period_timer_pkg::count_addr, 8'h00);
  endtask

  // A reset in mid-run must bring every register back to its reset value.
  task automatic t_midreset();
    wr_reg(period_timer_pkg::period_addr, 8'h10);
    wr_reg(period_timer_pkg::control_addr, 8'h7f);
    wr_reg(period_timer_pkg::flags_addr, 8'h02);
    repeat (40) @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
  endtask

  initial
  begin
    n_errors = 0;
    samples_checked = 0;
    bus_req = '0;
    rst_b = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_prescale();
    t_clear();
    t_postscale();
    t_irq_mask();
    t_set_wins();
    t_midreset();
    summarize();
  end

  // The whole sequence needs well under two thousand cycles.
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end
endmodule

`default_nettype wire
